// file: sim/arp_ctrl_assertions.sv
// Port checker for the protection sequencer.
// Assumes it is bound into arp_ctrl and given the same count parameters.
`default_nettype none
module arp_ctrl_assertions #(
    parameter int unsigned BLANK_CYC = 20,
    parameter int unsigned OVP_CYC   = 8
) (
    input wire logic              pclk,
    input wire logic              presetn,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pready,
    input wire arp_pkg::arp_cmp_t cmp_in,
    input wire logic              gate_enable,
    input wire logic              blank_clamp_switch,
    input wire logic              startup_cell_en,
    input wire logic              auto_restart
);
    timeunit 1ns;
    timeprecision 1ps;
    int unsigned ovl_cnt;
    int unsigned ov_cnt;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) ovl_cnt <= 0;
        else ovl_cnt <= cmp_in.overload ? ovl_cnt + 1 : 0;
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) ov_cnt <= 0;
        else ov_cnt <= (cmp_in.vcc_ov && !cmp_in.burst) ? ov_cnt + 1 : 0;
    end
    ////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_live; gate_enable && !auto_restart; endsequence
    property p_restart_off; auto_restart |-> !gate_enable && !startup_cell_en; endproperty
    a_restart_off: assert property (p_restart_off) else $error("switching in restart");
    property p_off_idle; startup_cell_en |-> !gate_enable; endproperty
    a_off_idle: assert property (p_off_idle) else $error("switching while off");
    property p_uv_off; cmp_in.vcc_uv [*3] |-> ##[1:3] startup_cell_en; endproperty
    a_uv_off: assert property (p_uv_off) else $error("no switch-off on undervoltage");
    property p_hot; $rose(cmp_in.overtemp) ##0 s_live ##1 cmp_in.overtemp [*2] |-> ##[1:3] auto_restart; endproperty
    a_hot: assert property (p_hot) else $error("late overtemperature restart");
    property p_clamp; $rose(blank_clamp_switch) |-> ovl_cnt >= BLANK_CYC; endproperty
    a_clamp: assert property (p_clamp) else $error("clamp opened early");
    property p_ovp; s_live ##0 (ov_cnt == OVP_CYC) |-> ##[1:4] auto_restart; endproperty
    a_ovp: assert property (p_ovp) else $error("no supply overvoltage restart");
    property p_exit; $fell(auto_restart) |-> $past(cmp_in.vcc_uv, 3) || $past(cmp_in.vcc_uv, 4); endproperty
    a_exit: assert property (p_exit) else $error("restart left without undervoltage");
    property p_ready; psel && !penable |=> pready; endproperty
    a_ready: assert property (p_ready) else $error("no access phase answer");
endmodule
bind arp_ctrl arp_ctrl_assertions #(.BLANK_CYC(BLANK_CYC), .OVP_CYC(OVP_CYC)) arp_chk_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pready(pready),
    .cmp_in(cmp_in), .gate_enable(gate_enable), .blank_clamp_switch(blank_clamp_switch),
    .startup_cell_en(startup_cell_en), .auto_restart(auto_restart));
`default_nettype wire

// file: sim/arp_sense_model.sv
// Comparator and blanking pin model facing the protection sequencer.
// Assumes levels in hundredths of a volt and the clamp switch output.
`default_nettype none
module arp_sense_model #(
    parameter int VCC_ON  = 1800,
    parameter int VCC_OFF = 1050
) (
    input  wire logic        pclk,
    input  var int           vcc_cv,
    input  var int           fb_cv,
    input  var int           temp_c,
    input  wire logic        burst,
    input  wire logic        ext_pull,
    input  var int           cap_div,
    input  wire logic        clamp_open,
    output arp_pkg::arp_cmp_t cmp
);
    timeunit 1ns;
    timeprecision 1ps;
    int pin_cv = 90;
    int tick = 0;
    always @(posedge pclk) begin
        tick <= (tick + 1 >= cap_div) ? 0 : tick + 1;
        if (ext_pull) pin_cv <= 10;
        else if (!clamp_open) pin_cv <= 90;
        else if (cap_div == 0) pin_cv <= 500;
        else if (tick == 0 && pin_cv < 500) pin_cv <= pin_cv + 1;
    end
    always_comb begin
        cmp.overload   = fb_cv > 400;
        cmp.blank_high = pin_cv >= 400;
        cmp.blank_low  = pin_cv < 33;
        cmp.vcc_ss_ov  = vcc_cv > 2050;
        cmp.vcc_ov     = vcc_cv > 2550;
        cmp.overtemp   = temp_c > 130;
        cmp.vcc_on     = vcc_cv >= VCC_ON;
        cmp.vcc_uv     = vcc_cv < VCC_OFF;
        cmp.burst      = burst;
    end
endmodule
`default_nettype wire

// file: sim/tb.sv
// Self-checking bench for the protection sequencer.
// Assumes the design, the sense model and the checker are compiled first.
`include "arp_consts.svh"
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int BLK = 20, SFT = 20, SPK = 4, OVP = 8, EXT = 10;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic brs = 1'b0, ext = 1'b0, e, pready, pslverr, irq;
    logic gate_enable, blank_clamp_switch, startup_cell_en, auto_restart;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, r;
    arp_pkg::arp_cmp_t cmp;
    int n_fail = 0, compares = 0, vcc = 0, fb = 200, tmp = 25, cap = 0;
    integer seed = 32'hb6f9;
    int t, nom, k, lo, hi, exp_stat;
    always #2 pclk = ~pclk;
    arp_ctrl #(.BLANK_CYC(BLK), .SOFT_CYC(SFT), .SPIKE_CYC(SPK), .OVP_CYC(OVP), .EXT_CYC(EXT))
    arp_ctrl_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .cmp_in(cmp), .gate_enable(gate_enable), .blank_clamp_switch(blank_clamp_switch),
        .startup_cell_en(startup_cell_en), .auto_restart(auto_restart), .irq(irq));
    arp_sense_model arp_sense_model_i (.pclk(pclk), .vcc_cv(vcc), .fb_cv(fb), .temp_c(tmp),
        .burst(brs), .ext_pull(ext), .cap_div(cap), .clamp_open(blank_clamp_switch), .cmp(cmp));
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    function automatic logic hit(input int w);
        case (w)
            0: return auto_restart === 1'b1;
            1: return gate_enable === 1'b1;
            2: return startup_cell_en === 1'b1;
            4: return blank_clamp_switch === 1'b1;
            default: return gate_enable === 1'b0;
        endcase
    endfunction
    task automatic wait_on(input int w, output int n);
        n = 0;
        while (!hit(w) && n < 3000) begin
            @(posedge pclk);
            n++;
        end
    endtask
    task automatic bring_up(input logic run, input logic x);
        @(posedge pclk);
        vcc <= 1000;
        fb <= 200;
        tmp <= 25;
        ext <= x;
        wait_on(2, t);
        apb(1'b1, `ARP_OFF_INT_STAT, 32'h0000_003f);
        exp_stat = 0;
        vcc <= nom;
        wait_on(1, t);
        if (run) repeat (SFT + 4) @(posedge pclk);
    endtask
    task automatic tally_and_finish;
        if (n_fail == 0 && compares > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (60000) @(posedge pclk);
        n_fail++;
        tally_and_finish;
    end
    initial begin
        nom = 1850 + $unsigned($random(seed)) % 100;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        for (k = 0; k < 5; k++) begin
            apb(1'b0, 12'(4 * k), '0);
            chk("reset value", r, k == 0);
            chk("slave error", e, k == 4);
        end
        apb(1'b1, `ARP_OFF_INT_MASK, 32'h0000_003f);
        for (k = 0; k < 6; k++) begin
            cap <= 1 + $unsigned($random(seed)) % 3;
            bring_up(k != 1 && k != 4, k == 4);
            if (k != 1 && k != 4) begin
                apb(1'b0, `ARP_OFF_STATUS, '0);
                chk("status after recheck", r, 32'h0000_0017);
            end
            @(posedge pclk);
            case (k)
                0: fb <= 450;
                1: begin
                    vcc <= 2100;
                    fb <= 450;
                end
                2: begin
                    brs <= 1'b1;
                    vcc <= 2600;
                end
                3: tmp <= 140;
                5: vcc <= 1000;
                default: ;
            endcase
            if (k == 2) begin
                repeat (OVP + 20) @(posedge pclk);
                chk("restart in burst", auto_restart, 1'b0);
                brs <= 1'b0;
            end
            if (k == 4) begin
                wait_on(3, t);
                chk("ignore window", t >= EXT - 1 && t <= EXT + 4, 1'b1);
            end
            if (k == 0) begin
                wait_on(4, t);
                chk("clamp open time", t, BLK + 3);
            end
            lo = k == 0 ? 310 * cap + SPK : k == 2 ? OVP : 0;
            hi = k == 0 ? lo + 16 : k == 2 ? OVP + 8 : SPK + 6;
            wait_on(k == 5 ? 2 : 0, t);
            chk("reaction time", t >= lo && t <= hi, 1'b1);
            exp_stat = exp_stat | (1 << k);
            apb(1'b0, `ARP_OFF_INT_STAT, '0);
            chk("event flags", r, exp_stat);
            chk("interrupt", irq, 1'b1);
            apb(1'b1, `ARP_OFF_INT_MASK, '0);
            apb(1'b0, `ARP_OFF_INT_STAT, '0);
            chk("masked interrupt", irq, 1'b0);
            apb(1'b1, `ARP_OFF_INT_STAT, 32'(exp_stat));
            exp_stat = 0;
            apb(1'b0, `ARP_OFF_INT_STAT, '0);
            chk("cleared flags", r, exp_stat);
            apb(1'b1, `ARP_OFF_INT_MASK, 32'h0000_003f);
        end
        apb(1'b1, `ARP_OFF_CTRL, '0);
        vcc <= nom;
        repeat (8) @(posedge pclk);
        chk("held off while disabled", startup_cell_en, 1'b1);
        apb(1'b1, `ARP_OFF_CTRL, 32'h0000_0001);
        wait_on(1, t);
        chk("start after enable", t >= 1 && t <= 3, 1'b1);
        tally_and_finish;
    end
endmodule
`default_nettype wire

// file: verilog/arp_consts.svh
// Constants of the auto restart protection sequencer.
// Assumes a 250 MHz pclk and a 32-bit APB register bus.
`ifndef ARP_CONSTS_SVH
`define ARP_CONSTS_SVH
`define ARP_CLK_MHZ      250
`define ARP_BLANK_MS     20
`define ARP_SOFT_MS      20
`define ARP_SPIKE_US     30
`define ARP_OVP_US       120
`define ARP_EXT_DLY_MS   1
`define ARP_OFF_CTRL     12'h000
`define ARP_OFF_STATUS   12'h004
`define ARP_OFF_INT_STAT 12'h008
`define ARP_OFF_INT_MASK 12'h00C
`define ARP_CTRL_RST     1'b1
`define ARP_MASK_RST     6'h00
`define ARP_EV_OVL       0
`define ARP_EV_SS_OV     1
`define ARP_EV_VCC_OV    2
`define ARP_EV_THERM     3
`define ARP_EV_EXT       4
`define ARP_EV_UVLO      5
`define ARP_EV_W         6
`endif

// file: verilog/arp_ctrl.sv
// Auto restart protection sequencer with APB registers and interrupt.
// Assumes comparator results arrive asynchronously and pclk runs at 250 MHz.
//
// Behaviour
// - Feedback level above 4.0V starts the internal blanking counter.
// - After 20ms of blanking, open the clamp switch on the blanking pin.
// - Blanking expired and pin at 4.0V, then 30us filter, gives restart.
// - Extension is the pin charge time from 0.9V to 4.0V.
// - In soft start, supply above 20.5V with feedback high restarts at once.
// - Supply above 25.5V for 120us restarts in soft start or run.
// - The 25.5V detection is off during active burst mode.
// - Overtemperature above 130C restarts at once, without extended blanking.
// - Blanking pin below 0.33V stops switching, restarts if it persists.
// - The external restart request is ignored for 1ms at start-up.
// - Supply below turn-off threshold switches off and enables startup cell.
// - Restart waits for undervoltage, then turn-on, runs soft start, rechecks, else resumes.
`include "arp_consts.svh"
`default_nettype none
module arp_ctrl #(
    parameter int unsigned BLANK_CYC = `ARP_BLANK_MS * `ARP_CLK_MHZ * 1000,
    parameter int unsigned SOFT_CYC  = `ARP_SOFT_MS * `ARP_CLK_MHZ * 1000,
    parameter int unsigned SPIKE_CYC = `ARP_SPIKE_US * `ARP_CLK_MHZ,
    parameter int unsigned OVP_CYC   = `ARP_OVP_US * `ARP_CLK_MHZ,
    parameter int unsigned EXT_CYC   = `ARP_EXT_DLY_MS * `ARP_CLK_MHZ * 1000
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic             psel,
    input  wire logic             penable,
    input  wire logic             pwrite,
    input  wire logic [11:0]      paddr,
    input  wire logic [31:0]      pwdata,
    output logic      [31:0]      prdata,
    output logic                  pready,
    output logic                  pslverr,
    input  wire arp_pkg::arp_cmp_t cmp_in,
    output logic                  gate_enable,
    output logic                  blank_clamp_switch,
    output logic                  startup_cell_en,
    output logic                  auto_restart,
    output logic                  irq
);

    ////////////////////////////////////////////////////////////////////////
    // Counter step: counts while the condition holds, saturating at limit.
    function automatic logic [31:0] cnt_step(input logic        cond,
                                             input logic [31:0] cnt,
                                             input logic [31:0] lim);
        if (!cond) begin
            cnt_step = 32'h0000_0000;
        end else if (cnt >= lim) begin
            cnt_step = lim;
        end else begin
            cnt_step = cnt + 32'h0000_0001;
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Comparator synchroniser.
    arp_pkg::arp_cmp_t cmp_meta_reg;
    arp_pkg::arp_cmp_t cmp_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmp_meta_reg <= '0;
            cmp_reg      <= '0;
        end else begin
            cmp_meta_reg <= cmp_in;
            cmp_reg      <= cmp_meta_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Declarations.
    arp_pkg::arp_state_t state_reg;
    arp_pkg::arp_state_t state_next;
    logic [31:0] blank_cnt_reg;
    logic [31:0] spike_cnt_reg;
    logic [31:0] ovp_cnt_reg;
    logic [31:0] ext_dly_reg;
    logic [31:0] ext_cnt_reg;
    logic [31:0] soft_cnt_reg;
    logic        ctrl_en_reg;
    logic [`ARP_EV_W-1:0] int_stat_reg;
    logic [`ARP_EV_W-1:0] int_mask_reg;
    logic [`ARP_EV_W-1:0] ev;
    logic        active;
    logic        blank_done;
    logic        ext_armed;
    logic        ext_req;
    logic        fault;
    logic        wr_en;
    logic [`ARP_EV_W-1:0] w1c;
    logic [`ARP_EV_W-1:0] int_stat_next;
    logic [`ARP_EV_W-1:0] int_mask_next;

    assign active     = (state_reg == arp_pkg::ARP_SOFT) || (state_reg == arp_pkg::ARP_RUN);
    assign blank_done = (blank_cnt_reg == BLANK_CYC);
    assign ext_armed  = (ext_dly_reg == EXT_CYC);
    assign ext_req    = ext_armed && cmp_reg.blank_low;

    ////////////////////////////////////////////////////////////////////////
    // Fault timers.
    // Each timer clears as soon as its condition drops, so only unbroken faults count.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            blank_cnt_reg <= 32'h0000_0000;
        end else begin
            blank_cnt_reg <= cnt_step(active && cmp_reg.overload,
                                      blank_cnt_reg, BLANK_CYC);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            spike_cnt_reg <= 32'h0000_0000;
        end else begin
            spike_cnt_reg <= cnt_step(active && blank_done && cmp_reg.blank_high,
                                      spike_cnt_reg, SPIKE_CYC);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ovp_cnt_reg <= 32'h0000_0000;
        end else begin
            ovp_cnt_reg <= cnt_step(active && cmp_reg.vcc_ov && !cmp_reg.burst,
                                    ovp_cnt_reg, OVP_CYC);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_dly_reg <= 32'h0000_0000;
        end else begin
            ext_dly_reg <= cnt_step(active, ext_dly_reg, EXT_CYC);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_cnt_reg <= 32'h0000_0000;
        end else begin
            ext_cnt_reg <= cnt_step(active && ext_req, ext_cnt_reg, SPIKE_CYC);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            soft_cnt_reg <= 32'h0000_0000;
        end else begin
            soft_cnt_reg <= cnt_step(state_reg == arp_pkg::ARP_SOFT,
                                     soft_cnt_reg, SOFT_CYC);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Fault events.
    always_comb begin
        ev = '0;
        ev[`ARP_EV_OVL]    = active && (spike_cnt_reg == SPIKE_CYC);
        ev[`ARP_EV_SS_OV]  = (state_reg == arp_pkg::ARP_SOFT) && cmp_reg.vcc_ss_ov
                             && cmp_reg.overload;
        ev[`ARP_EV_VCC_OV] = active && (ovp_cnt_reg == OVP_CYC);
        ev[`ARP_EV_THERM]  = active && cmp_reg.overtemp;
        ev[`ARP_EV_EXT]    = active && (ext_cnt_reg == SPIKE_CYC);
        ev[`ARP_EV_UVLO]   = (state_reg != arp_pkg::ARP_OFF) && cmp_reg.vcc_uv;
    end

    assign fault = |ev[`ARP_EV_EXT:`ARP_EV_OVL];

    ////////////////////////////////////////////////////////////////////////
    // Sequencer.
    // Undervoltage is tested first, since a collapsing supply overrides any pending fault.
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            arp_pkg::ARP_OFF: begin
                if (cmp_reg.vcc_on && ctrl_en_reg) begin
                    state_next = arp_pkg::ARP_SOFT;
                end
            end
            arp_pkg::ARP_SOFT: begin
                if (cmp_reg.vcc_uv) begin
                    state_next = arp_pkg::ARP_OFF;
                end else if (fault) begin
                    state_next = arp_pkg::ARP_RESTART;
                end else if (soft_cnt_reg == SOFT_CYC) begin
                    state_next = arp_pkg::ARP_RUN;
                end
            end
            arp_pkg::ARP_RUN: begin
                if (cmp_reg.vcc_uv) begin
                    state_next = arp_pkg::ARP_OFF;
                end else if (fault) begin
                    state_next = arp_pkg::ARP_RESTART;
                end
            end
            arp_pkg::ARP_RESTART: begin
                if (cmp_reg.vcc_uv) begin
                    state_next = arp_pkg::ARP_OFF;
                end
            end
            default: begin
                state_next = arp_pkg::ARP_OFF;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= arp_pkg::ARP_OFF;
        end else begin
            state_reg <= state_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Power stage outputs.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gate_enable        <= 1'b0;
            blank_clamp_switch <= 1'b0;
            startup_cell_en    <= 1'b1;
            auto_restart       <= 1'b0;
        end else begin
            gate_enable        <= ((state_next == arp_pkg::ARP_SOFT)
                                  || (state_next == arp_pkg::ARP_RUN))
                                  && !ext_req;
            blank_clamp_switch <= (state_next != arp_pkg::ARP_OFF)
                                  && (state_next != arp_pkg::ARP_RESTART)
                                  && (cnt_step(active && cmp_reg.overload, blank_cnt_reg,
                                               BLANK_CYC) == BLANK_CYC);
            startup_cell_en    <= (state_next == arp_pkg::ARP_OFF);
            auto_restart       <= (state_next == arp_pkg::ARP_RESTART);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // APB slave: one wait-free access cycle, pready high in the access phase.
    assign wr_en = psel && penable && pready && pwrite;
    assign w1c   = (wr_en && (paddr == `ARP_OFF_INT_STAT)) ? pwdata[`ARP_EV_W-1:0] : '0;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && (paddr != `ARP_OFF_CTRL)
                       && (paddr != `ARP_OFF_STATUS) && (paddr != `ARP_OFF_INT_STAT)
                       && (paddr != `ARP_OFF_INT_MASK);
            prdata  <= 32'h0000_0000;
            if (psel && !penable && !pwrite) begin
                case (paddr)
                    `ARP_OFF_CTRL:     prdata <= {31'h0000_0000, ctrl_en_reg};
                    `ARP_OFF_STATUS:   prdata <= {27'h000_0000, gate_enable,
                                                  blank_done, ext_armed, state_reg};
                    `ARP_OFF_INT_STAT: prdata <= {26'h000_0000, int_stat_reg};
                    `ARP_OFF_INT_MASK: prdata <= {26'h000_0000, int_mask_reg};
                    default:           prdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_en_reg  <= `ARP_CTRL_RST;
            int_mask_reg <= `ARP_MASK_RST;
        end else if (wr_en) begin
            if (paddr == `ARP_OFF_CTRL) begin
                ctrl_en_reg <= pwdata[0];
            end
            if (paddr == `ARP_OFF_INT_MASK) begin
                int_mask_reg <= pwdata[`ARP_EV_W-1:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sticky event flags; a new event wins over a clear in the same cycle.
    // The interrupt level uses the mask being written, so it never lags a mask write.
    assign int_stat_next = (int_stat_reg & ~w1c) | ev;
    assign int_mask_next = (wr_en && (paddr == `ARP_OFF_INT_MASK))
                           ? pwdata[`ARP_EV_W-1:0] : int_mask_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_stat_reg <= '0;
            irq          <= 1'b0;
        end else begin
            int_stat_reg <= int_stat_next;
            irq          <= |(int_stat_next & int_mask_next);
        end
    end

endmodule
`default_nettype wire

// file: verilog/arp_pkg.sv
// Types of the auto restart protection sequencer.
// Assumes nothing beyond the constants header.
`default_nettype none
package arp_pkg;
    typedef enum logic [1:0] {
        ARP_OFF     = 2'b00,
        ARP_SOFT    = 2'b01,
        ARP_RUN     = 2'b11,
        ARP_RESTART = 2'b10
    } arp_state_t;

    typedef struct packed {
        logic overload;
        logic blank_high;
        logic blank_low;
        logic vcc_ss_ov;
        logic vcc_ov;
        logic overtemp;
        logic vcc_on;
        logic vcc_uv;
        logic burst;
    } arp_cmp_t;
endpackage
`default_nettype wire
